// *** rtl/dtl_drive_terminal_logic.sv ***
// Drive control terminals: start decoding, flag routing, AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
module dtl_drive_terminal_logic (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        nrst,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// AXI4-Lite write response.
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Terminal pins, asynchronous, high when closed.
	input  wire logic        fwd_start_in,
	input  wire logic        rev_start_in,
	input  wire logic        assign_term_in,
	input  wire logic        jog_in,
	input  wire logic        output_shutoff_in,
	// Drive state from the same clock domain.
	input  wire logic [15:0] out_freq,
	input  wire logic [15:0] target_freq,
	input  wire logic        stall_active,
	input  wire logic [7:0]  regen_duty_pct,
	input  wire logic [7:0]  thermal_pct,
	input  wire logic        fault_in,
	// Commands to the drive.
	output var  logic        run_cmd_reg,
	output var  logic        reverse_cmd_reg,
	output var  logic        coast_stop_reg,
	output var  logic        drive_enable_reg,
	output var  logic        thermal_trip_reg,
	// Output terminals.
	output var  logic        first_oc_on,
	output var  logic        second_oc_on,
	output var  logic        relay_on
);
	// Synchronised pins: fwd, rev, assignable, jog, shutoff.
	logic [4:0] pin_meta_reg;
	logic [4:0] pin_sync_reg;
	logic       fwd_s, rev_s, term_s, jog_s, shut_s;
	logic       fwd_prev_reg, rev_prev_reg;
	// Settings.
	logic [13:0] stop_select_setting;
	logic [7:0]  input_assign_settings;
	logic        jog_enable_reg;
	logic [7:0]  first_oc_output_select, second_oc_output_select;
	logic [7:0]  relay_output_select, group_read_select;
	logic [15:0] start_freq_setting, detect_freq_fwd_setting;
	logic [15:0] detect_freq_rev_setting;
	logic [7:0]  regen_duty_setting;
	// Start decoding.
	logic hold_run_reg, hold_rev_reg;
	logic hold_mode, alt_mode, coast_mode, fwd_fall, rev_fall;
	logic run_next, rev_next;
	// Flags.
	logic [dtl_pkg::FLAG_W-1:0] flag_reg;
	logic [dtl_pkg::FLAG_W-1:0] flag_next;
	// Bus state.
	logic        aw_held_reg, w_held_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        do_write;
	logic [31:0] rd_word;
	logic        rd_ok;

	// Merges a write under byte strobes into an old word.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	// Tests a value against an inclusive range.
	function automatic logic in_range(input logic [13:0] v,
		input logic [13:0] lo, input logic [13:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// Two flip-flops on every pin before any logic looks at it.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_reg <= 5'h00;
			pin_sync_reg <= 5'h00;
		end else begin
			pin_meta_reg <= {fwd_start_in, rev_start_in, assign_term_in,
				jog_in, output_shutoff_in};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	assign {fwd_s, rev_s, term_s, jog_s, shut_s} = pin_sync_reg;

	// Previous levels for release detection.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fwd_prev_reg <= 1'b0;
			rev_prev_reg <= 1'b0;
		end else begin
			fwd_prev_reg <= fwd_s;
			rev_prev_reg <= rev_s;
		end
	end
	assign fwd_fall = fwd_prev_reg & ~fwd_s;
	assign rev_fall = rev_prev_reg & ~rev_s;

	assign hold_mode = (input_assign_settings == dtl_pkg::CODE_STOP_HOLD)
		& term_s & ~(jog_s & jog_enable_reg);
	assign alt_mode = (stop_select_setting == dtl_pkg::SEL_ALT_STOP) | in_range(
		stop_select_setting, dtl_pkg::SEL_ALT_MIN, dtl_pkg::SEL_ALT_MAX);
	assign coast_mode = (stop_select_setting <= dtl_pkg::SEL_COAST_MAX) |
		in_range(stop_select_setting, dtl_pkg::SEL_ALT_MIN,
		dtl_pkg::SEL_ALT_MAX);

	// Start latch; the last released input sets the direction.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hold_run_reg <= 1'b0;
			hold_rev_reg <= 1'b0;
		end else if (!hold_mode) begin
			hold_run_reg <= 1'b0;
			hold_rev_reg <= 1'b0;
		end else if (fwd_fall | rev_fall) begin
			hold_run_reg <= 1'b1;
			hold_rev_reg <= rev_fall & ~fwd_fall;
		end
	end

	always_comb begin
		if (hold_mode) begin
			run_next = hold_run_reg;
			rev_next = hold_rev_reg;
		end else if (alt_mode) begin
			run_next = fwd_s;
			rev_next = fwd_s & rev_s;
		end else begin
			run_next = fwd_s ^ rev_s;
			rev_next = rev_s & ~fwd_s;
		end
	end

	// Drive commands. Shutoff only gates the output; the latch lives on.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			run_cmd_reg      <= 1'b0;
			reverse_cmd_reg  <= 1'b0;
			coast_stop_reg   <= 1'b0;
			drive_enable_reg <= 1'b0;
		end else begin
			run_cmd_reg      <= run_next;
			reverse_cmd_reg  <= rev_next;
			coast_stop_reg   <= ~run_next & coast_mode & ~hold_mode;
			drive_enable_reg <= ~shut_s;
		end
	end

	// Internal flags; frequency compares assume equal units for all values.
	always_comb begin
		flag_next = '0;
		flag_next[dtl_pkg::FL_RUNNING] = run_cmd_reg & drive_enable_reg
			& (out_freq >= start_freq_setting);
		flag_next[dtl_pkg::FL_AT_SPEED] = run_cmd_reg
			& (out_freq >= target_freq);
		flag_next[dtl_pkg::FL_STALL] = stall_active;
		flag_next[dtl_pkg::FL_FREQ_DET] = out_freq >= (reverse_cmd_reg
			? detect_freq_rev_setting : detect_freq_fwd_setting);
		flag_next[dtl_pkg::FL_REGEN] = 16'(regen_duty_pct) * 16'h0064 >=
			16'(regen_duty_setting) * 16'(dtl_pkg::PREWARN_PCT);
		flag_next[dtl_pkg::FL_THERMAL] = thermal_pct >= dtl_pkg::PREWARN_PCT;
		flag_next[dtl_pkg::FL_FAULT] = fault_in
			| (thermal_pct >= dtl_pkg::THERMAL_TRIP_PCT);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flag_reg         <= '0;
			thermal_trip_reg <= 1'b0;
		end else begin
			flag_reg         <= flag_next;
			thermal_trip_reg <= thermal_pct >= dtl_pkg::THERMAL_TRIP_PCT;
		end
	end

	// One router per terminal, each registered.
	dtl_output_router u_first (.mclk(mclk), .nrst(nrst),
		.sel_code(first_oc_output_select), .flags(flag_reg),
		.term_on_reg(first_oc_on));
	dtl_output_router u_second (.mclk(mclk), .nrst(nrst),
		.sel_code(second_oc_output_select), .flags(flag_reg),
		.term_on_reg(second_oc_on));
	dtl_output_router u_relay (.mclk(mclk), .nrst(nrst),
		.sel_code(relay_output_select), .flags(flag_reg),
		.term_on_reg(relay_on));

	// Write channels are taken independently, then committed together.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end
	assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

	// Ready only while nothing of that channel is held or answered.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dtl_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_held_reg & ~s_axi_bvalid
				& ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_held_reg & ~s_axi_bvalid
				& ~(s_axi_wvalid & s_axi_wready);
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg
					<= dtl_pkg::OFS_REGEN_DUTY)
					? dtl_pkg::RESP_OKAY : dtl_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Settings write; status is read only.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stop_select_setting     <= dtl_pkg::RST_STOP_SEL;
			input_assign_settings   <= dtl_pkg::RST_IN_ASSIGN;
			jog_enable_reg          <= 1'b0;
			first_oc_output_select  <= dtl_pkg::RST_FIRST_OC;
			second_oc_output_select <= dtl_pkg::RST_SECOND_OC;
			relay_output_select     <= dtl_pkg::RST_RELAY;
			group_read_select       <= dtl_pkg::RST_GROUP_READ;
			start_freq_setting      <= dtl_pkg::RST_FREQ;
			detect_freq_fwd_setting <= dtl_pkg::RST_FREQ;
			detect_freq_rev_setting <= dtl_pkg::RST_FREQ;
			regen_duty_setting      <= 8'h00;
		end else if (do_write) begin
			case (aw_addr_reg)
				dtl_pkg::OFS_STOP_SEL: begin
					stop_select_setting <= 14'(merge(
						32'(stop_select_setting), w_data_reg, w_strb_reg));
				end
				dtl_pkg::OFS_IN_ASSIGN: begin
					{jog_enable_reg, input_assign_settings} <= 9'(merge(
						{23'h0, jog_enable_reg, input_assign_settings},
						w_data_reg, w_strb_reg));
				end
				dtl_pkg::OFS_OUT_SEL: begin
					if (group_read_select == 8'h00) begin
						{relay_output_select, second_oc_output_select,
							first_oc_output_select} <= 24'(merge(
							{8'h00, relay_output_select,
							second_oc_output_select,
							first_oc_output_select},
							w_data_reg, w_strb_reg));
					end
				end
				dtl_pkg::OFS_GROUP_READ: begin
					group_read_select <= 8'(merge(32'(group_read_select),
						w_data_reg, w_strb_reg));
				end
				dtl_pkg::OFS_START_FREQ: begin
					start_freq_setting <= 16'(merge(32'(start_freq_setting),
						w_data_reg, w_strb_reg));
				end
				dtl_pkg::OFS_DET_FWD: begin
					detect_freq_fwd_setting <= 16'(merge(
						32'(detect_freq_fwd_setting), w_data_reg, w_strb_reg));
				end
				dtl_pkg::OFS_DET_REV: begin
					detect_freq_rev_setting <= 16'(merge(
						32'(detect_freq_rev_setting), w_data_reg, w_strb_reg));
				end
				dtl_pkg::OFS_REGEN_DUTY: begin
					regen_duty_setting <= 8'(merge(32'(regen_duty_setting),
						w_data_reg, w_strb_reg));
				end
				default: begin
				end
			endcase
		end
	end

	// Read decode; unmapped words read zero with an error response.
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			dtl_pkg::OFS_STOP_SEL:   rd_word = 32'(stop_select_setting);
			dtl_pkg::OFS_IN_ASSIGN:  rd_word = 32'({jog_enable_reg,
				input_assign_settings});
			dtl_pkg::OFS_OUT_SEL:    rd_word = 32'({relay_output_select,
				second_oc_output_select, first_oc_output_select});
			dtl_pkg::OFS_GROUP_READ: rd_word = 32'(group_read_select);
			dtl_pkg::OFS_START_FREQ: rd_word = 32'(start_freq_setting);
			dtl_pkg::OFS_DET_FWD:    rd_word = 32'(detect_freq_fwd_setting);
			dtl_pkg::OFS_DET_REV:    rd_word = 32'(detect_freq_rev_setting);
			dtl_pkg::OFS_REGEN_DUTY: rd_word = 32'(regen_duty_setting);
			dtl_pkg::OFS_STATUS:     rd_word = 32'({flag_reg, relay_on,
				second_oc_on, first_oc_on, thermal_trip_reg, drive_enable_reg,
				coast_stop_reg, reverse_cmd_reg, run_cmd_reg, hold_mode,
				hold_rev_reg, hold_run_reg});
			default: begin
				rd_word = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Read channel: one cycle from address to data.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= dtl_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? dtl_pkg::RESP_OKAY
					: dtl_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks on the start logic and the settings lock.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_fwd_release;
		hold_mode && fwd_fall;
	endsequence

	AST_LATCH_ON_RELEASE:
		assert property (s_fwd_release |=> hold_run_reg && !hold_rev_reg)
		else $error("start release did not latch forward run");
	AST_REV_PULSE:
		assert property (hold_mode && rev_fall && !fwd_fall |=> hold_rev_reg)
		else $error("reverse pulse did not latch reverse");
	// Two-wire decoding takes over once stop-hold drops, so only an idle
	// pair of start inputs must leave the drive stopped.
	AST_STOP_CLEARS:
		assert property (hold_run_reg && !hold_mode && !fwd_s && !rev_s
			|=> !hold_run_reg && !run_cmd_reg)
		else $error("stop-hold release did not clear run");
	AST_JOG_MASKS:
		assert property (jog_s && jog_enable_reg |-> !hold_mode)
		else $error("jog did not mask stop-hold");
	AST_SHUTOFF:
		assert property (shut_s && hold_mode && !fwd_fall && !rev_fall
			|=> !drive_enable_reg && $stable(hold_run_reg))
		else $error("shutoff wrong effect on output or latch");
	AST_LEVEL_BOTH_STOP:
		assert property (!hold_mode && !alt_mode && fwd_s && rev_s
			|=> !run_cmd_reg)
		else $error("both inputs did not stop in level mode");
	AST_ALT_REVERSE:
		assert property (!hold_mode && alt_mode && fwd_s && rev_s
			|=> run_cmd_reg && reverse_cmd_reg)
		else $error("alternate mode did not run reverse");
	AST_OUT_SEL_LOCK:
		assert property (group_read_select != 8'h00
			|=> $stable(first_oc_output_select))
		else $error("output selection changed while locked");
endmodule : dtl_drive_terminal_logic
`default_nettype wire

// *** rtl/dtl_pkg.sv ***
// Shared constants for the drive terminal logic: map, fields, resets, codes.
package dtl_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_STOP_SEL   = 8'h00;
	localparam logic [7:0] OFS_IN_ASSIGN  = 8'h04;
	localparam logic [7:0] OFS_OUT_SEL    = 8'h08;
	localparam logic [7:0] OFS_GROUP_READ = 8'h0C;
	localparam logic [7:0] OFS_START_FREQ = 8'h10;
	localparam logic [7:0] OFS_DET_FWD    = 8'h14;
	localparam logic [7:0] OFS_DET_REV    = 8'h18;
	localparam logic [7:0] OFS_REGEN_DUTY = 8'h1C;
	localparam logic [7:0] OFS_STATUS     = 8'h20;
	// Field positions.
	localparam int IN_ASSIGN_JOG_EN_BIT = 8;
	localparam int OUT_SEL_SECOND_LSB   = 8;
	localparam int OUT_SEL_RELAY_LSB    = 16;
	// Reset values.
	localparam logic [13:0] RST_STOP_SEL   = 14'h270F;
	localparam logic [7:0]  RST_IN_ASSIGN  = 8'h00;
	localparam logic [7:0]  RST_FIRST_OC   = 8'h00;
	localparam logic [7:0]  RST_SECOND_OC  = 8'h04;
	localparam logic [7:0]  RST_RELAY      = 8'h63;
	localparam logic [7:0]  RST_GROUP_READ = 8'h00;
	localparam logic [15:0] RST_FREQ       = 16'h0000;
	// Stop selection values.
	localparam logic [13:0] SEL_LEVEL_STOP = 14'h270F;
	localparam logic [13:0] SEL_ALT_STOP   = 14'h22B8;
	localparam logic [13:0] SEL_COAST_MAX  = 14'h0064;
	localparam logic [13:0] SEL_ALT_MIN    = 14'h03E8;
	localparam logic [13:0] SEL_ALT_MAX    = 14'h044C;
	// Input assignment code that makes a terminal the stop-hold input.
	localparam logic [7:0] CODE_STOP_HOLD = 8'h19;
	// Output function codes (source polarity) and the sink offset.
	localparam logic [7:0] CODE_RUNNING  = 8'h00;
	localparam logic [7:0] CODE_AT_SPEED = 8'h01;
	localparam logic [7:0] CODE_STALL    = 8'h03;
	localparam logic [7:0] CODE_FREQ_DET = 8'h04;
	localparam logic [7:0] CODE_REGEN    = 8'h07;
	localparam logic [7:0] CODE_THERMAL  = 8'h08;
	localparam logic [7:0] CODE_FAULT    = 8'h63;
	localparam logic [7:0] CODE_SINK_OFS = 8'h64;
	// Prewarn and trip thresholds in percent.
	localparam logic [7:0] PREWARN_PCT     = 8'h55;
	localparam logic [7:0] THERMAL_TRIP_PCT = 8'h64;
	// Flag vector layout.
	localparam int FLAG_W = 7;
	typedef enum logic [2:0] {
		FL_RUNNING = 3'h0, FL_AT_SPEED = 3'h1, FL_STALL = 3'h2,
		FL_FREQ_DET = 3'h3, FL_REGEN = 3'h4, FL_THERMAL = 3'h5,
		FL_FAULT = 3'h6
	} dtl_flag_e;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dtl_pkg

// *** rtl/dtl_output_router.sv ***
// Output routing of one terminal: code to flag, with source or sink polarity.
`timescale 1ns/1ps
`default_nettype none
module dtl_output_router (
	// Clock and reset.
	input  wire logic                      mclk,
	input  wire logic                      nrst,
	// Selection code and internal flags.
	input  wire logic [7:0]                sel_code,
	input  wire logic [dtl_pkg::FLAG_W-1:0] flags,
	// Terminal drive, high turns the output on.
	output var  logic                      term_on_reg
);
	logic hit;
	logic level;
	logic [7:0] base;

	// Maps a source code to its flag; unknown codes give no hit.
	function automatic logic pick(input logic [7:0] c,
		input logic [dtl_pkg::FLAG_W-1:0] f, output logic h);
		h = 1'b1;
		case (c)
			dtl_pkg::CODE_RUNNING:  pick = f[dtl_pkg::FL_RUNNING];
			dtl_pkg::CODE_AT_SPEED: pick = f[dtl_pkg::FL_AT_SPEED];
			dtl_pkg::CODE_STALL:    pick = f[dtl_pkg::FL_STALL];
			dtl_pkg::CODE_FREQ_DET: pick = f[dtl_pkg::FL_FREQ_DET];
			dtl_pkg::CODE_REGEN:    pick = f[dtl_pkg::FL_REGEN];
			dtl_pkg::CODE_THERMAL:  pick = f[dtl_pkg::FL_THERMAL];
			dtl_pkg::CODE_FAULT:    pick = f[dtl_pkg::FL_FAULT];
			default: begin
				pick = 1'b0;
				h = 1'b0;
			end
		endcase
	endfunction : pick

	always_comb begin
		base = (sel_code >= dtl_pkg::CODE_SINK_OFS)
			? sel_code - dtl_pkg::CODE_SINK_OFS : sel_code;
		level = pick(base, flags, hit);
	end

	// sink inverts flag
	// An unassigned code leaves the terminal off in either polarity.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			term_on_reg <= 1'b0;
		end else begin
			term_on_reg <= hit & (level ^ (sel_code >= dtl_pkg::CODE_SINK_OFS));
		end
	end
endmodule : dtl_output_router
`default_nettype wire

// *** testbench/dtl_term_partner.sv ***
// Operator switches and PLC contacts that drive the control terminals.
`timescale 1ns/1ps
`default_nettype none
module dtl_term_partner (
	// Clock for switching changes.
	input  wire logic mclk,
	// Terminal contacts, high when closed.
	output var  logic fwd_start_in,
	output var  logic rev_start_in,
	output var  logic assign_term_in,
	output var  logic jog_in,
	output var  logic output_shutoff_in
);
	// Contacts start open so no start is seen during reset.
	initial begin
		{fwd_start_in, rev_start_in, assign_term_in} = 3'h0;
		{jog_in, output_shutoff_in} = 2'h0;
	end
	// Order: forward, reverse, assignable, jog, shutoff.
	task automatic set(input logic [4:0] v);
		@(posedge mclk);
		{fwd_start_in, rev_start_in, assign_term_in} <= v[4:2];
		{jog_in, output_shutoff_in} <= v[1:0];
	endtask : set
	// one start pulse
	// The contact closes for a few cycles so the synchroniser sees it.
	task automatic pulse(input logic rv);
		@(posedge mclk);
		if (rv) rev_start_in <= 1'b1;
		else fwd_start_in <= 1'b1;
		repeat (4) @(posedge mclk);
		fwd_start_in <= 1'b0;
		rev_start_in <= 1'b0;
	endtask : pulse
endmodule : dtl_term_partner
`default_nettype wire

// *** testbench/dtl_drive_terminal_logic_tb.sv ***
// Self-checking bench: bus accesses, start decoding and output routing.
`timescale 1ns/1ps
`default_nettype none
module dtl_drive_terminal_logic_tb;
	logic mclk = 1'b0, nrst = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rdp = 8'h00, thermal_prewarn = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, fault = 1'b0, stall = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic fwd, rev, term, jog, shut, run, rvs, coast, en, trip, oc1, oc2, rly;
	logic [15:0] ofreq = 16'h0000, tfreq = 16'h0000;
	int error_cnt = 0, samples_checked = 0;
	// Clock at 250 MHz.
	always #2 mclk = ~mclk;
	dtl_term_partner p (.mclk(mclk), .fwd_start_in(fwd), .rev_start_in(rev),
		.assign_term_in(term), .jog_in(jog), .output_shutoff_in(shut));
	dtl_drive_terminal_logic dut (.mclk(mclk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .fwd_start_in(fwd),
		.rev_start_in(rev), .assign_term_in(term), .jog_in(jog),
		.output_shutoff_in(shut), .out_freq(ofreq), .target_freq(tfreq),
		.stall_active(stall), .regen_duty_pct(rdp), .thermal_pct(thermal_prewarn),
		.fault_in(fault), .run_cmd_reg(run), .reverse_cmd_reg(rvs),
		.coast_stop_reg(coast), .drive_enable_reg(en), .thermal_trip_reg(trip),
		.first_oc_on(oc1), .second_oc_on(oc2), .relay_on(rly));
	// Verdict in one place so a timeout ends the same way.
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic hang();
		error_cnt++;
		conclude();
	endtask : hang
	// Address and data go out together; each drops once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge mclk);
		{awaddr, wdata} <= {a, v};
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 64) hang();
		bready <= 1'b0;
		r = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge mclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 64) hang();
		rready <= 1'b0;
		{d, r} = {rdata, rresp};
	endtask : rd
	// Synchroniser, decode and routing take a handful of edges.
	task automatic settle();
		repeat (10) @(posedge mclk);
	endtask : settle
	logic [1:0] lv [4] = '{2'b00, 2'b11, 2'b10, 2'b00};
	logic [1:0] al [4] = '{2'b00, 2'b00, 2'b10, 2'b11};
	int i;
	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(dtl_pkg::OFS_OUT_SEL);
		chk("out select", d, 32'h00630400);
		rd(dtl_pkg::OFS_STOP_SEL);
		chk("stop select", d, 32'h0000270F);
		rd(8'h24);
		chk("unmapped resp", {30'h0, r}, {30'h0, dtl_pkg::RESP_SLVERR});
		$display("test reset done");
		// Table rows: fwd,rev = 00,01,10,11 against run,reverse.
		for (i = 0; i < 4; i++) begin
			p.set({i[1:0], 3'h0});
			settle();
			chk("level run", {run, rvs}, lv[i]);
		end
		wr(dtl_pkg::OFS_STOP_SEL, 32'h000022B8);
		for (i = 0; i < 4; i++) begin
			p.set({i[1:0], 3'h0});
			settle();
			chk("alt run", {run, rvs}, al[i]);
		end
		// A timed stop selection coasts once the start is removed.
		p.set(5'h00);
		wr(dtl_pkg::OFS_STOP_SEL, 32'h00000064);
		settle();
		chk("coast", coast, 1'b1);
		wr(dtl_pkg::OFS_STOP_SEL, 32'h0000270F);
		settle();
		chk("no coast", coast, 1'b0);
		$display("test decoding done");
		// Wrong code: the terminal is not stop-hold, a pulse does not latch.
		p.set(5'h04);
		p.pulse(1'b0);
		settle();
		chk("no hold run", run, 1'b0);
		wr(dtl_pkg::OFS_IN_ASSIGN, 32'h00000019);
		p.pulse(1'b0);
		settle();
		chk("held fwd", {run, rvs}, 2'b10);
		p.pulse(1'b1);
		settle();
		chk("held rev", {run, rvs}, 2'b11);
		p.set(5'h05);
		settle();
		chk("shutoff en", en, 1'b0);
		rd(dtl_pkg::OFS_STATUS);
		chk("latch kept", d[0], 1'b1);
		p.set(5'h00);
		settle();
		chk("hold off run", run, 1'b0);
		// Latch again, then let an enabled jog input mask stop-hold.
		p.set(5'h04);
		p.pulse(1'b0);
		settle();
		chk("held again", run, 1'b1);
		wr(dtl_pkg::OFS_IN_ASSIGN, 32'h00000119);
		p.set(5'h06);
		settle();
		rd(dtl_pkg::OFS_STATUS);
		chk("jog masks", {run, d[2:0]}, 4'h0);
		p.set(5'h00);
		$display("test self hold done");
		fault <= 1'b1;
		settle();
		chk("relay fault", rly, 1'b1);
		wr(dtl_pkg::OFS_OUT_SEL, 32'h00C70800);
		thermal_prewarn <= 8'h55;
		settle();
		chk("relay sink", rly, 1'b0);
		chk("thermal warn", {oc2, trip}, 2'b10);
		thermal_prewarn <= 8'h64;
		settle();
		chk("thermal trip", trip, 1'b1);
		wr(dtl_pkg::OFS_GROUP_READ, 32'h00000001);
		wr(dtl_pkg::OFS_OUT_SEL, 32'h00000000);
		rd(dtl_pkg::OFS_OUT_SEL);
		chk("locked sel", d, 32'h00C70800);
		$display("test outputs done");
		// Flags from drive state; first terminal on stall in sink polarity.
		fault <= 1'b0;
		thermal_prewarn <= 8'h00;
		wr(dtl_pkg::OFS_GROUP_READ, 32'h00000000);
		wstrb <= 4'h1;
		wr(dtl_pkg::OFS_OUT_SEL, 32'hFFFFFF67);
		wstrb <= 4'hF;
		rd(dtl_pkg::OFS_OUT_SEL);
		chk("byte strobe", d, 32'h00C70867);
		wr(dtl_pkg::OFS_START_FREQ, 32'h00000010);
		wr(dtl_pkg::OFS_DET_FWD, 32'h00000020);
		wr(dtl_pkg::OFS_DET_REV, 32'h00000005);
		wr(dtl_pkg::OFS_REGEN_DUTY, 32'h00000014);
		{ofreq, tfreq, stall, rdp} <= {16'h0018, 16'h0030, 1'b1, 8'h11};
		p.set(5'h10);
		settle();
		rd(dtl_pkg::OFS_STATUS);
		chk("flags fwd", d[17:11], 7'h15);
		chk("stall sink", oc1, 1'b0);
		{tfreq, stall, rdp} <= {16'h0018, 1'b0, 8'h10};
		p.set(5'h08);
		settle();
		rd(dtl_pkg::OFS_STATUS);
		chk("flags rev", d[17:11], 7'h0B);
		chk("stall clear", oc1, 1'b1);
		p.set(5'h00);
		$display("test flags done");
		conclude();
	end
	// Whole-run guard.
	initial begin
		repeat (20000) @(posedge mclk);
		hang();
	end
endmodule : dtl_drive_terminal_logic_tb
`default_nettype wire
